// [sss_store_regs.vh]
// Constants of the store-command executor: register map, field layout,
// reset values, source codes and error codes.
// Assumes inclusion by the executor and its bench; definitions, no logic.
`ifndef SSS_STORE_REGS_VH
`define SSS_STORE_REGS_VH

// Register byte offsets on the bus
`define SSS_OFF_CTRL 4'h0
`define SSS_OFF_STATUS 4'h4
`define SSS_OFF_JOBADDR 4'h8
`define SSS_OFF_COUNT 4'hC

// Control register bit positions and reset value
`define SSS_CTRL_LE 0
`define SSS_CTRL_EN 1
`define SSS_CTRL_CLRERR 8
`define SSS_CTRL_RESET 2'h2
`define SSS_JOBADDR_RESET 32'h00000000

// Status register field positions
`define SSS_ST_BUSY 0
`define SSS_ST_ERR 1
`define SSS_ST_CODE_LO 8
`define SSS_ST_SRC_LO 16

// Command word fields
`define SSS_F_TYPE 31:27
`define SSS_F_CLASS 26:25
`define SSS_F_FLAG 24
`define SSS_F_IMM 23
`define SSS_F_SRC 22:16
`define SSS_F_OFF 15:8
`define SSS_F_LEN 7:0

// Command types
`define SSS_TYPE_STORE 5'h0A
`define SSS_TYPE_SEQ 5'h0B

// Source select codes
`define SSS_SRC_CTRLIMM 7'h00
`define SSS_SRC_STAT 7'h02
`define SSS_SRC_CHKSUM 7'h03
`define SSS_SRC_CTX 7'h20
`define SSS_SRC_KEYBUF 7'h40
`define SSS_SRC_JOBWB 7'h41
`define SSS_SRC_MSGIMM 7'h7E

// Size limits
`define SSS_WORD_BYTES 8'h04
`define SSS_DBUF_WORDS 9'h040
`define SSS_MATH_MAX 8'h40
`define SSS_MATH_OFF_MAX 8'h07
`define SSS_CTX_MAX 8'h80
`define SSS_CHK_LEN 8'h02

// Error codes
`define SSS_ERR_NONE 4'h0
`define SSS_ERR_SRC 4'h1
`define SSS_ERR_IMM 4'h2
`define SSS_ERR_FORM 4'h3
`define SSS_ERR_KEY 4'h4
`define SSS_ERR_TYPE 4'h5

`endif

// [sss_store_exec.v]
// Store-command executor: decodes a store command word, checks source,
// class, length and offset, fetches pointer or immediate words, reads
// the chosen source and writes it word by word to the DMA master.
// Assumes command stream, source port and DMA port share clk.
// Behaviour
// RL1: type 0Ah plain with pointer, 0Bh sequence
// RL2: immediate source 00h control, 7Eh message, else error
// RL3: offset counts words for buffer, else bytes
// RL4: length counts words for buffer, else bytes
// RL5: no pointer for sequence or write-back forms
// RL6: plain store of 40h carries a pointer
// RL7: immediate data fills rounded-up whole words
// RL8: word registers accept only 4/0, 8/0, 4/4
// RL9: 00h reads mode or job queue control
// RL10: status store: conditions, index, output count
// RL11: checksum is message data, only 2/0
// RL12: 04h class 3 reads context identifier
// RL13: class 0 06h-09h read control registers
// RL14: math word view, offset 0-7, shrinking length
// RL15: math double-word view, offset zero only
// RL16: math byte view may span registers
// RL17: class 1 10h-13h read operand sizes
// RL18: context up to 128, waits accelerator done
// RL19: key readable only before key size written
// RL20: buffer copy errors when length+offset over 64
// RL21: 41h plain form only, writes job back
// RL22: unlisted pairs stop job with error
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "sss_store_regs.vh"

module sss_store_exec (
  input wire clk,
  input wire rstn,
  input wire ce,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Command word stream
  input wire [31:0] cmdWord,
  input wire cmdValid,
  output wire cmdReady,
  // Job context
  input wire [31:0] seqOutAddr,
  input wire [7:0] varSeqOutLen,
  input wire [3:0] mathCond,
  input wire [7:0] cmdIndex,
  input wire [31:0] seqOutCount,
  input wire class1Done,
  input wire class2Done,
  input wire class1KeySizeWritten,
  input wire class2KeySizeWritten,
  // Source read port, data one cycle after request
  output wire srcRdReq,
  output reg [6:0] srcRdSel,
  output reg [1:0] srcRdClass,
  output reg [9:0] srcRdAddr,
  input wire [31:0] srcRdData,
  // DMA write master
  output wire dmaValid,
  input wire dmaReady,
  output reg [31:0] dmaAddr,
  output reg [31:0] dmaData,
  output reg [2:0] dmaBytes,
  output reg dmaScatter,
  // Job events
  output reg jobAbort,
  output reg storeDone,
  output wire busy
);

  // One-hot states
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_PTR = 7'h02;
  localparam [6:0] ST_WAIT = 7'h04;
  localparam [6:0] ST_RD = 7'h08;
  localparam [6:0] ST_CAP = 7'h10;
  localparam [6:0] ST_WR = 7'h20;
  localparam [6:0] ST_IMM = 7'h40;

  reg [6:0] state_q, state_d;
  reg [1:0] ctrl_q; // Enable and little-endian
  reg [31:0] jobAddr_q; // Job descriptor fetch address
  reg errFlag_q; // Sticky command error
  reg [3:0] errCode_q;
  reg [6:0] lastSrc_q;
  reg [15:0] count_q; // Completed stores
  reg [8:0] bytesLeft_q; // Bytes still to write
  reg imm_q, msg_q, stat_q, stall1_q;
  reg [31:0] statHi_q, statLo_q; // Snapshot for status store

  // Decoded command fields
  wire [4:0] command_type = cmdWord[`SSS_F_TYPE];
  wire [1:0] cCls = cmdWord[`SSS_F_CLASS];
  wire cFlag = cmdWord[`SSS_F_FLAG];
  wire cImm = cmdWord[`SSS_F_IMM];
  wire [6:0] cSrc = cmdWord[`SSS_F_SRC];
  wire [7:0] cOff = cmdWord[`SSS_F_OFF];
  wire cSeq = (command_type == `SSS_TYPE_SEQ);
  // Variable length only in the sequence form
  wire [7:0] cLen = (cSeq && cFlag) ? varSeqOutLen : cmdWord[`SSS_F_LEN];
  // Descriptor buffer sources count in words
  wire cDbuf = (cSrc == `SSS_SRC_JOBWB) ||
    (cSrc == `SSS_SRC_KEYBUF && cCls == 2'h3);

  // Word-register length/offset pairs
  function pairOk(input [7:0] l, input [7:0] o);
    begin
      // RL8: three legal pairs
      pairOk = (o == 8'h00 && (l == `SSS_WORD_BYTES ||
        l == (`SSS_WORD_BYTES << 1))) ||
        (l == `SSS_WORD_BYTES && o == `SSS_WORD_BYTES);
    end
  endfunction

  // Source/class/length/offset legality for register sources
  function srcOk(input [6:0] s, input [1:0] c, input [7:0] l,
    input [7:0] o);
    reg [7:0] lim;
    reg pr, mth;
    begin
      pr = pairOk(l, o);
      lim = `SSS_MATH_MAX - {2'h0, s[2:0], 3'h0};
      mth = (o <= `SSS_MATH_OFF_MAX) && (l <= lim);
      case (s)
        // RL9: mode regs or job queue control
        7'h00, 7'h01, 7'h02: srcOk = (c != 2'h0) && pr;
        // RL11: checksum only 2/0
        7'h03: srcOk = (c == 2'h3) ? (l == `SSS_CHK_LEN &&
          o == 8'h00) : ((c != 2'h0) && pr);
        // RL12: context identifier register
        7'h04: srcOk = (c == 2'h3) && pr;
        // RL13: class 0 control registers
        7'h06, 7'h07: srcOk = (c == 2'h0) && pr;
        // RL14: math word view shares 08h and 09h
        7'h08, 7'h09: srcOk = (c == 2'h0) ? pr : ((c == 2'h3) && mth);
        7'h0A, 7'h0D, 7'h0E, 7'h0F: srcOk = (c == 2'h3) && mth;
        7'h0B, 7'h0C: srcOk = (c == 2'h1) ? pr :
          ((c == 2'h3) && mth);
        // RL17: operand size registers
        7'h10, 7'h11, 7'h12, 7'h13: srcOk = (c == 2'h1) && pr;
        // RL18: context up to 128 bytes
        7'h20: srcOk = (c == 2'h1 || c == 2'h2) &&
          l <= `SSS_CTX_MAX && o <= `SSS_CTX_MAX;
        // RL15: double-word view, offset zero
        7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h36, 7'h37:
          srcOk = (c == 2'h3) && o == 8'h00 && l <= lim;
        // RL16: byte view spans contiguous registers
        7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F:
          srcOk = (c == 2'h3) && mth;
        // RL20: buffer copy bound
        7'h40: srcOk = (c == 2'h3) ? ({1'b0, l} + {1'b0, o} <=
          `SSS_DBUF_WORDS) : ((c != 2'h0) && l <= `SSS_CTX_MAX &&
          o <= `SSS_CTX_MAX);
        7'h41: srcOk = (c == 2'h3) && ({1'b0, l} + {1'b0, o} <=
          `SSS_DBUF_WORDS);
        // RL22: everything else refused
        default: srcOk = 1'b0;
      endcase
    end
  endfunction

  // Byte swap within a word when enabled
  function [31:0] swap(input [31:0] w, input en);
    begin
      swap = en ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    end
  endfunction

  // Byte-lane merge for bus writes
  function [31:0] merge(input [31:0] old, input [31:0] nw,
    input [3:0] sel);
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Command check: error code for the word in front
  reg [3:0] chkCode;
  always @* begin
    chkCode = `SSS_ERR_NONE;
    // RL1: only the two store types
    if (!cSeq && command_type != `SSS_TYPE_STORE) begin
      chkCode = `SSS_ERR_TYPE;
    end else if (cImm) begin
      // RL2: immediate needs class 0, 00h or 7Eh, no table
      if (cCls != 2'h0 || cOff != 8'h00 || (!cSeq && cFlag)) begin
        chkCode = `SSS_ERR_IMM;
      end else if (cSrc != `SSS_SRC_CTRLIMM &&
        cSrc != `SSS_SRC_MSGIMM) begin
        chkCode = `SSS_ERR_IMM;
      end
    end else if (cSrc == `SSS_SRC_JOBWB && (cSeq || cFlag)) begin
      // RL21: write-back only in plain form, no table
      chkCode = `SSS_ERR_FORM;
    end else if (!srcOk(cSrc, cCls, cLen, cOff)) begin
      // RL22: unlisted source or bad size
      chkCode = `SSS_ERR_SRC;
    end else if (cSrc == `SSS_SRC_KEYBUF &&
      ((cCls == 2'h1 && class1KeySizeWritten) ||
      (cCls == 2'h2 && class2KeySizeWritten))) begin
      // RL19: key locked once its size is written
      chkCode = `SSS_ERR_KEY;
    end
  end

  // Byte count of the whole store
  // RL4: words for the buffer, bytes otherwise
  wire [8:0] cBytes = cDbuf ? {cLen[6:0], 2'h0} : {1'b0, cLen};
  // RL3: buffer offset scaled to bytes
  wire [9:0] cOffB = cDbuf ? {cOff, 2'h0} : {2'h0, cOff};
  // RL5: pointer only for plain form outside write-back
  // RL6: plain 40h takes the pointer path
  wire cNeedPtr = !cSeq && (cSrc != `SSS_SRC_JOBWB || cImm);
  // RL18: context store waits for its accelerator
  wire stallDone = srcRdClass[0] ? class1Done : class2Done;
  wire curBytesGt4 = bytesLeft_q > {5'h0, `SSS_WORD_BYTES};
  wire lastWord = !curBytesGt4;

  // Handshakes follow the state directly
  assign cmdReady = ctrl_q[`SSS_CTRL_EN] &&
    (state_q == ST_IDLE || state_q == ST_PTR || state_q == ST_IMM);
  assign srcRdReq = (state_q == ST_RD);
  assign dmaValid = (state_q == ST_WR);
  assign busy = (state_q != ST_IDLE);

  // Next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmdValid && cmdReady && chkCode == `SSS_ERR_NONE) begin
          if (cNeedPtr) begin
            state_d = ST_PTR;
          end else if (cBytes == 9'h000) begin
            state_d = ST_IDLE;
          end else if (cImm) begin
            state_d = ST_IMM;
          end else if (cSrc == `SSS_SRC_CTX) begin
            state_d = ST_WAIT;
          end else begin
            state_d = ST_RD;
          end
        end
      end
      ST_PTR: begin
        if (cmdValid) begin
          if (bytesLeft_q == 9'h000) begin
            state_d = ST_IDLE;
          end else if (imm_q) begin
            state_d = ST_IMM;
          end else if (stall1_q) begin
            state_d = ST_WAIT;
          end else begin
            state_d = ST_RD;
          end
        end
      end
      ST_WAIT: begin
        if (stallDone) begin
          state_d = ST_RD;
        end
      end
      ST_RD: state_d = ST_CAP;
      ST_CAP: state_d = ST_WR;
      ST_WR: begin
        if (dmaReady) begin
          if (lastWord) begin
            state_d = ST_IDLE;
          end else if (imm_q) begin
            state_d = ST_IMM;
          end else begin
            state_d = ST_RD;
          end
        end
      end
      ST_IMM: begin
        if (cmdValid) begin
          state_d = ST_WR;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Datapath and job-level state
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      bytesLeft_q <= 9'h000;
      imm_q <= 1'b0;
      msg_q <= 1'b0;
      stat_q <= 1'b0;
      stall1_q <= 1'b0;
      statHi_q <= 32'h00000000;
      statLo_q <= 32'h00000000;
      srcRdSel <= 7'h00;
      srcRdClass <= 2'h0;
      srcRdAddr <= 10'h000;
      dmaAddr <= 32'h00000000;
      dmaData <= 32'h00000000;
      dmaBytes <= 3'h0;
      dmaScatter <= 1'b0;
      jobAbort <= 1'b0;
      storeDone <= 1'b0;
      lastSrc_q <= 7'h00;
      count_q <= 16'h0000;
    end else if (ce) begin
      state_q <= state_d;
      jobAbort <= 1'b0;
      storeDone <= 1'b0;
      if (state_q == ST_IDLE && cmdValid && cmdReady) begin
        lastSrc_q <= cSrc;
        // RL22: refused command aborts the job
        jobAbort <= (chkCode != `SSS_ERR_NONE);
        bytesLeft_q <= cBytes;
        imm_q <= cImm;
        // RL2: immediate 7Eh is message data
        // RL11: checksum treated as message data
        msg_q <= cImm ? (cSrc == `SSS_SRC_MSGIMM) :
          ((cSrc == `SSS_SRC_CHKSUM && cCls == 2'h3) ||
          cSrc == `SSS_SRC_CTX ||
          (cSrc == `SSS_SRC_KEYBUF && cCls != 2'h3));
        // RL10: snapshot conditions, index and count
        stat_q <= !cImm && cSrc == `SSS_SRC_STAT && cCls == 2'h3;
        statHi_q <= {mathCond, 20'h00000, cmdIndex};
        statLo_q <= seqOutCount;
        stall1_q <= !cImm && cSrc == `SSS_SRC_CTX;
        srcRdSel <= cSrc;
        srcRdClass <= cCls;
        srcRdAddr <= cOffB;
        dmaScatter <= !cSeq && cFlag;
        // RL21: job write-back reuses fetch address
        if (cSrc == `SSS_SRC_JOBWB && !cImm) begin
          dmaAddr <= jobAddr_q + {22'h0, cOffB};
        end else begin
          dmaAddr <= seqOutAddr;
        end
      end
      if (state_q == ST_PTR && cmdValid) begin
        dmaAddr <= cmdWord;
      end
      // RL10: other sources come from the read port
      if (state_q == ST_CAP) begin
        if (stat_q) begin
          dmaData <= swap(srcRdAddr[2] ? statLo_q : statHi_q,
            ctrl_q[`SSS_CTRL_LE]);
        end else begin
          dmaData <= swap(srcRdData, ctrl_q[`SSS_CTRL_LE] && !msg_q);
        end
        dmaBytes <= curBytesGt4 ? 3'h4 : bytesLeft_q[2:0];
      end
      // RL7: immediate words until length covered
      if (state_q == ST_IMM && cmdValid) begin
        dmaData <= swap(cmdWord, ctrl_q[`SSS_CTRL_LE] && !msg_q);
        dmaBytes <= curBytesGt4 ? 3'h4 : bytesLeft_q[2:0];
      end
      if (state_q == ST_WR && dmaReady) begin
        dmaAddr <= dmaAddr + 32'h00000004;
        srcRdAddr <= srcRdAddr + 10'h004;
        bytesLeft_q <= lastWord ? 9'h000 :
          bytesLeft_q - {1'b0, `SSS_WORD_BYTES};
        if (lastWord) begin
          storeDone <= 1'b1;
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end

  // Bus slave: registered ack and read data, one wait state
  wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wbWr = wbReq && wb_we_i;
  wire clrErr = wbWr && wb_adr_i == `SSS_OFF_CTRL && wb_sel_i[1] &&
    wb_dat_i[`SSS_CTRL_CLRERR];
  wire setErr = state_q == ST_IDLE && cmdValid && cmdReady &&
    chkCode != `SSS_ERR_NONE;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_q <= `SSS_CTRL_RESET;
      jobAddr_q <= `SSS_JOBADDR_RESET;
      errFlag_q <= 1'b0;
      errCode_q <= `SSS_ERR_NONE;
    end else if (ce) begin
      wb_ack_o <= wbReq;
      // New error wins over a same-cycle clear
      if (setErr) begin
        errFlag_q <= 1'b1;
        errCode_q <= chkCode;
      end else if (clrErr) begin
        errFlag_q <= 1'b0;
        errCode_q <= `SSS_ERR_NONE;
      end
      if (wbWr && wb_adr_i == `SSS_OFF_CTRL && wb_sel_i[0]) begin
        ctrl_q <= wb_dat_i[1:0];
      end
      if (wbWr && wb_adr_i == `SSS_OFF_JOBADDR) begin
        jobAddr_q <= merge(jobAddr_q, wb_dat_i, wb_sel_i);
      end
      // Unmapped offsets read as zero but still acknowledge
      case (wb_adr_i)
        `SSS_OFF_CTRL: wb_dat_o <= {30'h0, ctrl_q};
        `SSS_OFF_STATUS: wb_dat_o <= {9'h000, lastSrc_q, 4'h0,
          errCode_q, 6'h00, errFlag_q, busy};
        `SSS_OFF_JOBADDR: wb_dat_o <= jobAddr_q;
        `SSS_OFF_COUNT: wb_dat_o <= {16'h0000, count_q};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule

// [sss_store_exec_sva.sv]
// Port checker of the store executor: bus, DMA and source-read timing.
// Assumes one clock domain and is bound to every executor instance.
`timescale 1ns/1ps
module sss_store_exec_sva (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire dmaValid,
  input wire dmaReady,
  input wire [31:0] dmaAddr,
  input wire [31:0] dmaData,
  input wire [2:0] dmaBytes,
  input wire srcRdReq,
  input wire [6:0] srcRdSel,
  input wire [1:0] srcRdClass,
  input wire [9:0] srcRdAddr,
  input wire class1Done,
  input wire class2Done,
  input wire class1KeySizeWritten,
  input wire jobAbort,
  input wire storeDone,
  input wire busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_ackOne;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackOne: assert property (p_ackOne)
    else $error("bus ack held beyond one cycle");
  property p_ackNext;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o;
  endproperty
  a_ackNext: assert property (p_ackNext)
    else $error("bus request not answered next cycle");
  // Offered word must not move while memory stalls
  property p_dmaHold;
    dmaValid && !dmaReady |=> dmaValid && $stable(dmaAddr)
      && $stable(dmaData) && $stable(dmaBytes);
  endproperty
  a_dmaHold: assert property (p_dmaHold)
    else $error("DMA word changed before ready");
  property p_dmaBytes;
    dmaValid |-> dmaBytes != 3'h0 && dmaBytes <= 3'h4;
  endproperty
  a_dmaBytes: assert property (p_dmaBytes)
    else $error("DMA byte count out of range");
  property p_doneHs;
    storeDone |-> $past(dmaValid && dmaReady);
  endproperty
  a_doneHs: assert property (p_doneHs)
    else $error("store done without a final handshake");
  property p_abortOne;
    jobAbort |=> !jobAbort;
  endproperty
  a_abortOne: assert property (p_abortOne)
    else $error("abort pulse longer than one cycle");
  property p_idleQuiet;
    !busy |-> !dmaValid && !srcRdReq;
  endproperty
  a_idleQuiet: assert property (p_idleQuiet)
    else $error("traffic while idle");
  // Class 1 context may only be read once class 1 is done
  property p_ctxWait;
    srcRdReq && srcRdSel == 7'h20 && srcRdClass == 2'h1 |-> class1Done;
  endproperty
  a_ctxWait: assert property (p_ctxWait)
    else $error("context read before accelerator done");
  property p_keyLock;
    srcRdReq && srcRdSel == 7'h40 && srcRdClass == 2'h1
      |-> !class1KeySizeWritten;
  endproperty
  a_keyLock: assert property (p_keyLock)
    else $error("key read after key size written");
  property p_bufRange;
    srcRdReq && srcRdSel == 7'h40 && srcRdClass == 2'h3
      |-> srcRdAddr < 10'h100;
  endproperty
  a_bufRange: assert property (p_bufRange)
    else $error("descriptor buffer read beyond 64 words");
endmodule

bind sss_store_exec sss_store_exec_sva chk (
  .clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dmaValid(dmaValid),
  .dmaReady(dmaReady), .dmaAddr(dmaAddr), .dmaData(dmaData),
  .dmaBytes(dmaBytes), .srcRdReq(srcRdReq), .srcRdSel(srcRdSel),
  .srcRdClass(srcRdClass), .srcRdAddr(srcRdAddr), .class1Done(class1Done),
  .class2Done(class2Done), .class1KeySizeWritten(class1KeySizeWritten),
  .jobAbort(jobAbort), .storeDone(storeDone), .busy(busy));

// [sss_mem_model.sv]
// System memory model behind the DMA write master.
// Assumes destinations below 100h; slow makes ready alternate.
`timescale 1ns/1ps
module sss_mem_model (
  input wire clk,
  input wire rstn,
  input wire slow,
  input wire dmaValid,
  input wire [31:0] dmaAddr,
  input wire [31:0] dmaData,
  input wire [2:0] dmaBytes,
  output reg dmaReady
);
  reg [31:0] mem [0:63]; // Word store, wraps above 100h
  reg [2:0] lastBytes; // Valid bytes of the last word
  // Ready prompt, or every other cycle to stall the master
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dmaReady <= 1'b0;
    end else begin
      dmaReady <= slow ? ~dmaReady : 1'b1;
    end
  end
  // Words land only at a handshake edge
  always @(posedge clk) begin
    if (rstn && dmaValid && dmaReady) begin
      mem[dmaAddr[7:2]] <= dmaData;
      lastBytes <= dmaBytes;
    end
  end
endmodule

// [store_source_select_bench.sv]
// Self-checking bench of the store executor: bus, commands and memory.
// Assumes the checker is bound and the memory model sits on the DMA port.
`timescale 1ns/1ps
`include "sss_store_regs.vh"
module store_source_select_bench;
  reg clk, rstn, cyc, stb, we, cmdValid, c1Done, keyLock, slow;
  reg [3:0] adr, mathCond;
  reg [7:0] cmdIndex;
  reg [31:0] wdat, cmdWord, seqOutAddr, seqOutCount, srcData, rd;
  reg [31:0] ok [0:11]; // Legal sequence stores
  reg [35:0] bad [0:10]; // Error code over a refused command
  wire ack, cmdReady, srcRdReq, dmaValid, dmaReady, storeDone, jobAbort;
  wire [31:0] wbDat, dmaAddr, dmaData;
  wire [6:0] rdSel;
  wire [1:0] rdCls;
  wire [9:0] rdAddr;
  wire [2:0] dmaBytes;
  integer nErrors, cmpCount, nDone, i;

  sss_store_exec dut (
    .clk(clk), .rstn(rstn), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(wbDat), .wb_ack_o(ack), .cmdWord(cmdWord),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .seqOutAddr(seqOutAddr),
    .varSeqOutLen(8'h08), .mathCond(mathCond), .cmdIndex(cmdIndex),
    .seqOutCount(seqOutCount), .class1Done(c1Done), .class2Done(1'b1),
    .class1KeySizeWritten(keyLock), .class2KeySizeWritten(1'b0),
    .srcRdReq(srcRdReq), .srcRdSel(rdSel), .srcRdClass(rdCls),
    .srcRdAddr(rdAddr), .srcRdData(srcData), .dmaValid(dmaValid),
    .dmaReady(dmaReady), .dmaAddr(dmaAddr), .dmaData(dmaData),
    .dmaBytes(dmaBytes), .dmaScatter(), .jobAbort(jobAbort),
    .storeDone(storeDone), .busy());
  sss_mem_model mm (
    .clk(clk), .rstn(rstn), .slow(slow), .dmaValid(dmaValid),
    .dmaAddr(dmaAddr), .dmaData(dmaData), .dmaBytes(dmaBytes),
    .dmaReady(dmaReady));

  // Source port: tagged word a cycle after request, garbage otherwise
  always @(posedge clk) begin
    srcData <= srcRdReq ? {rdCls, rdSel, 13'h0, rdAddr} : ~srcData;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function [31:0] cw(input [4:0] t, input [1:0] c, input m,
    input [6:0] s, input [7:0] o, input [7:0] l);
    cw = {t, c, 1'b0, m, s, o, l};
  endfunction
  function [31:0] okw(input [1:0] c, input [6:0] s, input [7:0] l);
    okw = cw(5'h0B, c, 1'b0, s, 8'h00, l);
  endfunction

  task stopTest;
    begin
      if (nErrors == 0 && cmpCount > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task bail;
    begin
      nErrors = nErrors + 1;
      stopTest;
    end
  endtask
  task chk(input [31:0] exp, input [31:0] got);
    begin
      cmpCount = cmpCount + 1;
      if (got !== exp) begin
        nErrors = nErrors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Classic single cycle held until ack, then one idle cycle
  task wbx(input w, input [3:0] a, input [31:0] d);
    integer k;
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (k = 0; k < 20; k = k + 1) begin
        @(posedge clk);
        if (ack) break;
      end
      if (k == 20) bail;
      rd = wbDat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Command word held until taken; valid stays up for the next word
  task snd(input [31:0] w);
    integer k;
    begin
      cmdWord <= w;
      cmdValid <= 1'b1;
      for (k = 0; k < 50; k = k + 1) begin
        @(posedge clk);
        if (cmdReady) break;
      end
      if (k == 50) bail;
    end
  endtask
  // Outcome: 1 for store done, 2 for abort
  task fin(input [1:0] exp);
    integer k;
    reg [1:0] got;
    begin
      cmdValid <= 1'b0;
      got = 2'h0;
      for (k = 0; k < 300 && got == 2'h0; k = k + 1) begin
        @(posedge clk);
        if (storeDone) got = 2'h1;
        if (jobAbort) got = 2'h2;
      end
      if (got == 2'h0) bail;
      chk({30'h0, exp}, {30'h0, got});
      if (got == 2'h1) nDone = nDone + 1;
    end
  endtask

  initial begin
    {rstn, cyc, stb, we, cmdValid, keyLock, slow} = 7'h00;
    c1Done = 1'b1;
    adr = 4'h0;
    wdat = 32'h0;
    cmdWord = 32'h0;
    seqOutAddr = 32'h80;
    seqOutCount = 32'h1234;
    mathCond = 4'hA;
    cmdIndex = 8'h5C;
    srcData = 32'h0;
    nErrors = 0;
    cmpCount = 0;
    nDone = 0;
    ok[0] = okw(2'h1, 7'h00, 8'h04);
    ok[1] = okw(2'h2, 7'h00, 8'h08);
    ok[2] = okw(2'h3, 7'h00, 8'h04);
    ok[3] = okw(2'h3, 7'h04, 8'h04);
    ok[4] = okw(2'h0, 7'h06, 8'h04);
    ok[5] = okw(2'h0, 7'h09, 8'h08);
    ok[6] = okw(2'h1, 7'h13, 8'h04);
    ok[7] = okw(2'h3, 7'h08, 8'h40);
    ok[8] = okw(2'h3, 7'h37, 8'h08);
    ok[9] = okw(2'h3, 7'h38, 8'h14);
    ok[10] = okw(2'h1, 7'h40, 8'h04);
    ok[11] = okw(2'h3, 7'h03, 8'h02);
    bad[0] = {4'h1, cw(5'h0B, 2'h3, 1'b0, 7'h04, 8'h00, 8'h02)};
    bad[1] = {4'h1, cw(5'h0B, 2'h3, 1'b0, 7'h04, 8'h04, 8'h08)};
    bad[2] = {4'h1, cw(5'h0B, 2'h3, 1'b0, 7'h03, 8'h00, 8'h04)};
    bad[3] = {4'h1, cw(5'h0B, 2'h3, 1'b0, 7'h0F, 8'h00, 8'h09)};
    bad[4] = {4'h1, cw(5'h0B, 2'h3, 1'b0, 7'h30, 8'h01, 8'h08)};
    bad[5] = {4'h1, cw(5'h0B, 2'h3, 1'b0, 7'h40, 8'h08, 8'h39)};
    bad[6] = {4'h1, cw(5'h0B, 2'h0, 1'b0, 7'h05, 8'h00, 8'h04)};
    bad[7] = {4'h2, cw(5'h0B, 2'h0, 1'b1, 7'h05, 8'h00, 8'h04)};
    bad[8] = {4'h3, cw(5'h0B, 2'h3, 1'b0, 7'h41, 8'h00, 8'h01)};
    bad[9] = {4'h4, cw(5'h0B, 2'h1, 1'b0, 7'h40, 8'h00, 8'h04)};
    bad[10] = {4'h5, cw(5'h03, 2'h3, 1'b0, 7'h04, 8'h00, 8'h04)};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset values, an unmapped hole, write-back base
    wbx(1'b0, `SSS_OFF_CTRL, 32'h0);
    chk(32'h2, rd);
    wbx(1'b0, `SSS_OFF_STATUS, 32'h0);
    chk(32'h0, rd);
    wbx(1'b0, 4'h2, 32'h0);
    chk(32'h0, rd);
    wbx(1'b1, `SSS_OFF_JOBADDR, 32'hC0);
    wbx(1'b0, `SSS_OFF_JOBADDR, 32'h0);
    chk(32'hC0, rd);
    // Buffer copy with pointer, memory stalling, word units
    slow <= 1'b1;
    snd(cw(5'h0A, 2'h3, 1'b0, 7'h40, 8'h01, 8'h02));
    snd(32'h10);
    fin(2'h1);
    chk({2'h3, 7'h40, 23'h4}, mm.mem[4]);
    chk({2'h3, 7'h40, 23'h8}, mm.mem[5]);
    slow <= 1'b0;
    // Status store to the output sequence, no pointer
    snd(cw(5'h0B, 2'h3, 1'b0, 7'h02, 8'h00, 8'h08));
    fin(2'h1);
    chk({mathCond, 20'h0, cmdIndex}, mm.mem[32]);
    chk(seqOutCount, mm.mem[33]);
    // Five immediate bytes take two words, last one partial
    snd(cw(5'h0B, 2'h0, 1'b1, 7'h7E, 8'h00, 8'h05));
    snd(32'h11223344);
    snd(32'h55667788);
    fin(2'h1);
    chk(32'h11223344, mm.mem[32]);
    chk(32'h1, {29'h0, mm.lastBytes});
    // Little-endian: control data swapped, message data not
    wbx(1'b1, `SSS_OFF_CTRL, 32'h3);
    for (i = 0; i < 2; i = i + 1) begin
      snd(cw(5'h0B, 2'h0, 1'b1, i ? 7'h7E : 7'h00, 8'h00, 8'h04));
      snd(32'h11223344);
      fin(2'h1);
      chk(i ? 32'h11223344 : 32'h44332211, mm.mem[32]);
    end
    wbx(1'b1, `SSS_OFF_CTRL, 32'h2);
    // Job write-back: one word, base plus word offset
    snd(cw(5'h0A, 2'h3, 1'b0, 7'h41, 8'h02, 8'h01));
    fin(2'h1);
    chk({2'h3, 7'h41, 23'h8}, mm.mem[50]);
    // Context store stalls until the accelerator is done
    c1Done <= 1'b0;
    snd(cw(5'h0B, 2'h1, 1'b0, 7'h20, 8'h00, 8'h04));
    cmdValid <= 1'b0;
    for (i = 0; i < 12; i = i + 1) begin
      @(posedge clk);
      chk(32'h0, {31'h0, dmaValid});
    end
    c1Done <= 1'b1;
    fin(2'h1);
    chk({2'h1, 7'h20, 23'h0}, mm.mem[32]);
    // Legal sources read the expected register
    for (i = 0; i < 12; i = i + 1) begin
      snd(ok[i]);
      fin(2'h1);
      chk({ok[i][26:25], ok[i][22:16], 23'h0}, mm.mem[32]);
    end
    // Refused commands abort and report their code
    keyLock <= 1'b1;
    for (i = 0; i < 11; i = i + 1) begin
      snd(bad[i][31:0]);
      fin(2'h2);
      wbx(1'b0, `SSS_OFF_STATUS, 32'h0);
      chk({27'h0, bad[i][35:32], 1'b1}, {27'h0, rd[11:8], rd[1]});
      wbx(1'b1, `SSS_OFF_CTRL, 32'h102);
    end
    keyLock <= 1'b0;
    wbx(1'b0, `SSS_OFF_COUNT, 32'h0);
    chk(nDone, {16'h0, rd[15:0]});
    stopTest;
  end
endmodule
